// [rtl/cs_pkg.sv]
// constants, register map and carriers of the charger supervisor
package cs_pkg;
  localparam int CLK_NS       = 40;
  localparam int MS_NS        = 1000000;
  localparam int MS_CYC       = MS_NS / CLK_NS;
  localparam int INT_NS       = 256000;
  localparam int INT_CYC      = (INT_NS + CLK_NS - 1) / CLK_NS;
  localparam int HC_OFF_MS    = 32;
  localparam int HC_OFF_CYC   = HC_OFF_MS * MS_CYC;
  localparam int HC_ON_NS     = 260000;
  localparam int HC_ON_CYC    = (HC_ON_NS + CLK_NS - 1) / CLK_NS;
  localparam int BSHORT_NS    = 1000000;
  localparam int BSHORT_CYC   = (BSHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int USB_MIN      = 45;
  localparam int USB_MS       = USB_MIN * 60 * 1000;
  localparam int SAFE_HR      = 12;
  localparam int SAFE_MS      = SAFE_HR * 3600 * 1000;
  localparam int WD1_MS       = 40000;
  localparam int WD2_MS       = 80000;
  localparam int WD3_MS       = 160000;
  localparam int BLINK_BIT    = 8;

  localparam logic [7:0] A_CHG_CTRL = 8'h00;
  localparam logic [7:0] A_TMR_CTRL = 8'h04;
  localparam logic [7:0] A_THM_CTRL = 8'h08;
  localparam logic [7:0] A_IN_SRC   = 8'h0c;
  localparam logic [7:0] A_STATUS   = 8'h10;
  localparam logic [7:0] A_FAULT    = 8'h14;

  localparam int B_WD_KICK    = 6;
  localparam int B_CHG_EN     = 4;
  localparam int B_HIZ        = 7;
  localparam int B_TREG       = 1;
  localparam logic       RST_CHG_EN  = 1'b1;
  localparam logic [1:0] RST_WD_SEL  = 2'h1;
  localparam logic [1:0] RST_THM_SEL = 2'h3;
  localparam logic       RST_HIZ     = 1'b0;
  localparam logic [1:0] CF_NONE  = 2'h0;
  localparam logic [1:0] CF_INOV  = 2'h1;
  localparam logic [1:0] CF_TSD   = 2'h2;
  localparam logic [1:0] CF_TIMER = 2'h3;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef struct packed {
    logic       uvlo_ok;
    logic       above_bat;
    logic       input_overvoltage;
    logic       src_ok;
    logic       system_overvoltage;
    logic       tsd;
    logic       treg;
    logic       boost;
    logic       boost_ocp;
    logic       boost_ovp;
    logic       battery_overvoltage;
    logic       bat_short;
    logic       bat_low;
    logic       src_100ma;
    logic       src_id;
    logic       charging;
    logic       done;
    logic       chg_susp;
    logic [2:0] thermistor;
  } cs_sense_t;

  typedef struct packed {
    logic       conv_stop;
    logic       input_high_impedance;
    logic       charge_en;
    logic       reduce_current;
    logic       term_off;
    logic       timer_half;
    logic       blocking_switch;
    logic       battery_switch;
    logic       charge_100ma;
    logic       boost_exit;
    logic [1:0] thermal_sel;
  } cs_ctrl_t;

  typedef enum logic [2:0] {HC_ON = 3'h1, HC_OFF = 3'h2, HC_TRY = 3'h4} cs_hc_t;
  typedef enum logic [2:0] {BS_RUN = 3'h1, BS_OPEN = 3'h2, BS_LOW = 3'h4} cs_bs_t;
endpackage

// [rtl/cs_supervisor.sv]
// charger status, fault and mode supervisor with AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
module cs_supervisor #(
  parameter int P_MS_CYC     = cs_pkg::MS_CYC,
  parameter int P_INT_CYC    = cs_pkg::INT_CYC,
  parameter int P_HC_OFF_CYC = cs_pkg::HC_OFF_CYC,
  parameter int P_HC_ON_CYC  = cs_pkg::HC_ON_CYC,
  parameter int P_BSHORT_CYC = cs_pkg::BSHORT_CYC,
  parameter int P_USB_MS     = cs_pkg::USB_MS,
  parameter int P_SAFE_MS    = cs_pkg::SAFE_MS
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // analog comparator levels
  input  wire cs_pkg::cs_sense_t sense,
  // status pins and analog controls
  output logic                  input_good_n,
  output logic                  stat_o,
  output logic                  stat_oe,
  output logic                  int_o,
  output logic                  int_oe,
  output cs_pkg::cs_ctrl_t      ctrl,
  // register bus
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import cs_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    if (a == A_CHG_CTRL) mapped = 1'b1;
    else if (a == A_TMR_CTRL) mapped = 1'b1;
    else if (a == A_THM_CTRL) mapped = 1'b1;
    else if (a == A_IN_SRC) mapped = 1'b1;
    else if (a == A_STATUS) mapped = 1'b1;
    else if (a == A_FAULT) mapped = 1'b1;
    else mapped = 1'b0;
  endfunction

  cs_sense_t   s1_r;
  cs_sense_t   sn;
  cs_sense_t   sq;
  logic        good;
  logic        good_q;
  logic [31:0] ms_cnt_r;
  logic        ms_tick;
  logic        default_r;
  logic        chg_en_r;
  logic [1:0]  wd_sel_r;
  logic [1:0]  thm_sel_r;
  logic        hiz_r;
  logic        aw_ok_r;
  logic        w_ok_r;
  logic [7:0]  awaddr_r;
  logic [7:0]  wdata_r;
  logic        wstrb_r;
  logic        wr_go;
  logic        rd_go;
  logic        rd_fault;
  logic        kick;
  logic [31:0] wd_ms_r;
  logic [31:0] wd_lim;
  logic        wd_exp;
  logic [31:0] usb_ms_r;
  logic        usb_hiz_r;
  logic [31:0] safe_ms_r;
  logic        half_r;
  logic        safe_exp_r;
  logic        safe_ev;
  logic        boost_flt_r;
  logic [1:0]  chg_flt_r;
  logic        bat_flt_r;
  logic        pend_r;
  logic        flt_ev;
  logic [1:0]  chg_live;
  logic        int_ev;
  logic [31:0] int_cnt_r;
  cs_hc_t      hc_r;
  logic [31:0] hc_cnt_r;
  cs_bs_t      bs_r;
  logic [31:0] bs_cnt_r;
  logic [7:0]  fault_rd;
  logic [7:0]  status_rd;

  // two-stage synchroniser, then one stage for edges
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s1_r <= '0;
      sn   <= '0;
      sq   <= '0;
    end
    else
    begin
      s1_r <= sense;
      sn   <= s1_r;
      sq   <= sn;
    end

  assign good   = sn.uvlo_ok & sn.above_bat & ~sn.input_overvoltage & sn.src_ok;
  assign good_q = sq.uvlo_ok & sq.above_bat & ~sq.input_overvoltage & sq.src_ok;

  // millisecond enable
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      ms_cnt_r <= '0;
    else if (ms_cnt_r == 32'(P_MS_CYC - 1))
      ms_cnt_r <= '0;
    else
      ms_cnt_r <= ms_cnt_r + 32'h1;
  assign ms_tick = (ms_cnt_r == 32'(P_MS_CYC - 1));

  // bus slave
  assign wr_go    = aw_ok_r & w_ok_r & ~s_axi_bvalid;
  assign rd_go    = s_axi_arvalid & s_axi_arready;
  assign rd_fault = rd_go & (s_axi_araddr == A_FAULT);
  assign kick     = wr_go & wstrb_r & (awaddr_r == A_CHG_CTRL) & wdata_r[B_WD_KICK];

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      aw_ok_r       <= 1'b0;
      w_ok_r        <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb_r       <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_ok_r       <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_ok_r       <= 1'b1;
        wdata_r      <= s_axi_wdata[7:0];
        wstrb_r      <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_ok_r      <= 1'b0;
        w_ok_r       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awaddr_r) ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end

  assign chg_live  = sn.tsd ? CF_TSD : (sn.input_overvoltage && !sn.boost) ? CF_INOV :
                     safe_exp_r ? CF_TIMER : CF_NONE;
  assign fault_rd  = {default_r, boost_flt_r, chg_flt_r, bat_flt_r, sn.thermistor};
  assign status_rd = {6'h0, sn.treg, 1'b0};

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end
    else if (rd_go)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
      if (s_axi_araddr == A_CHG_CTRL) s_axi_rdata <= {27'h0, chg_en_r, 4'h0};
      else if (s_axi_araddr == A_TMR_CTRL) s_axi_rdata <= {26'h0, wd_sel_r, 4'h0};
      else if (s_axi_araddr == A_THM_CTRL) s_axi_rdata <= {30'h0, thm_sel_r};
      else if (s_axi_araddr == A_IN_SRC) s_axi_rdata <= {24'h0, hiz_r | usb_hiz_r, 7'h0};
      else if (s_axi_araddr == A_STATUS) s_axi_rdata <= {24'h0, status_rd};
      else if (s_axi_araddr == A_FAULT) s_axi_rdata <= {24'h0, fault_rd};
      else s_axi_rdata <= '0;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end

  // mode and software registers
  always_comb
    if (wd_sel_r == 2'h1) wd_lim = 32'(WD1_MS);
    else if (wd_sel_r == 2'h2) wd_lim = 32'(WD2_MS);
    else wd_lim = 32'(WD3_MS);
  assign wd_exp = ~default_r & (wd_sel_r != 2'h0) & (wd_ms_r >= wd_lim);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wd_ms_r <= '0;
    else if (default_r || kick || wd_exp || wd_sel_r == 2'h0)
      wd_ms_r <= '0;
    else if (ms_tick)
      wd_ms_r <= wd_ms_r + 32'h1;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      default_r <= 1'b1;
      chg_en_r  <= RST_CHG_EN;
      wd_sel_r  <= RST_WD_SEL;
      thm_sel_r <= RST_THM_SEL;
      hiz_r     <= RST_HIZ;
    end
    else if (wr_go)
    begin
      default_r <= 1'b0;
      if (wstrb_r && awaddr_r == A_CHG_CTRL) chg_en_r <= wdata_r[B_CHG_EN];
      if (wstrb_r && awaddr_r == A_TMR_CTRL) wd_sel_r <= wdata_r[5:4];
      if (wstrb_r && awaddr_r == A_THM_CTRL) thm_sel_r <= wdata_r[1:0];
      if (wstrb_r && awaddr_r == A_IN_SRC) hiz_r <= wdata_r[B_HIZ];
    end
    else if (wd_exp)
    begin
      default_r <= 1'b1;
      chg_en_r  <= RST_CHG_EN;
      wd_sel_r  <= RST_WD_SEL;
      thm_sel_r <= RST_THM_SEL;
      hiz_r     <= RST_HIZ;
    end

  // 100 mA source timer in default mode
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      usb_ms_r  <= '0;
      usb_hiz_r <= 1'b0;
    end
    else if (default_r && !sn.uvlo_ok)
    begin
      usb_ms_r  <= '0;
      usb_hiz_r <= 1'b0;
    end
    else if (default_r && sn.src_100ma && sn.charging && ms_tick)
    begin
      if (usb_ms_r >= 32'(P_USB_MS - 1))
        usb_hiz_r <= 1'b1;
      else
        usb_ms_r <= usb_ms_r + 32'h1;
    end

  // fast-charge safety timer, half rate in thermal regulation
  assign safe_ev = ms_tick & ~half_r & sn.charging & ~safe_exp_r & (safe_ms_r >= 32'(P_SAFE_MS - 1));
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      safe_ms_r  <= '0;
      half_r     <= 1'b0;
      safe_exp_r <= 1'b0;
    end
    else if (wr_go && wstrb_r && awaddr_r == A_CHG_CTRL && wdata_r[B_CHG_EN] && !chg_en_r)
    begin
      safe_ms_r  <= '0;
      safe_exp_r <= 1'b0;
    end
    else if (sn.charging && !safe_exp_r && ms_tick)
    begin
      half_r <= sn.treg ? ~half_r : 1'b0;
      if (safe_ev)
        safe_exp_r <= 1'b1;
      else if (!half_r)
        safe_ms_r <= safe_ms_r + 32'h1;
    end

  // fault latch: a read reloads live state, new events win over the read
  assign flt_ev = (sn.tsd & ~sq.tsd) | (sn.input_overvoltage & ~sq.input_overvoltage & ~sn.boost)
                | (sn.boost_ocp & ~sq.boost_ocp) | (sn.boost_ovp & ~sq.boost_ovp)
                | (sn.battery_overvoltage & ~sq.battery_overvoltage) | safe_ev;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      boost_flt_r <= 1'b0;
      chg_flt_r   <= CF_NONE;
      bat_flt_r   <= 1'b0;
      pend_r      <= 1'b0;
    end
    else
    begin
      if (rd_fault)
      begin
        boost_flt_r <= sn.boost_ocp | sn.boost_ovp;
        chg_flt_r   <= chg_live;
        bat_flt_r   <= sn.battery_overvoltage;
      end
      if ((sn.boost_ocp & ~sq.boost_ocp) | (sn.boost_ovp & ~sq.boost_ovp))
        boost_flt_r <= 1'b1;
      if (sn.tsd & ~sq.tsd)
        chg_flt_r <= CF_TSD;
      else if (sn.input_overvoltage & ~sq.input_overvoltage & ~sn.boost)
        chg_flt_r <= CF_INOV;
      else if (safe_ev)
        chg_flt_r <= CF_TIMER;
      if (sn.battery_overvoltage & ~sq.battery_overvoltage)
        bat_flt_r <= 1'b1;
      if (flt_ev)
        pend_r <= 1'b1;
      else if (rd_fault)
        pend_r <= 1'b0;
    end

  // interrupt pulse
  assign int_ev = (sn.src_id & ~sq.src_id) | (good & ~good_q) | (~good & good_q)
                | (sn.done & ~sq.done) | (flt_ev & ~pend_r)
                | (sn.thermistor != sq.thermistor);

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      int_cnt_r <= '0;
      int_oe    <= 1'b0;
      int_o     <= 1'b0;
    end
    else
    begin
      if (int_ev)
        int_cnt_r <= 32'(P_INT_CYC);
      else if (int_cnt_r != 32'h0)
        int_cnt_r <= int_cnt_r - 32'h1;
      int_oe <= int_ev | (int_cnt_r > 32'h1);
    end

  // boost hiccup on overcurrent
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      hc_r     <= HC_ON;
      hc_cnt_r <= '0;
    end
    else
    begin
      hc_cnt_r <= hc_cnt_r + 32'h1;
      case (hc_r)
        HC_ON:
          if (sn.boost && sn.boost_ocp)
          begin
            hc_r     <= HC_OFF;
            hc_cnt_r <= '0;
          end
        HC_OFF:
          if (hc_cnt_r >= 32'(P_HC_OFF_CYC - 1))
          begin
            hc_r     <= HC_TRY;
            hc_cnt_r <= '0;
          end
        HC_TRY:
          if (hc_cnt_r >= 32'(P_HC_ON_CYC - 1))
          begin
            hc_r     <= sn.boost_ocp ? HC_OFF : HC_ON;
            hc_cnt_r <= '0;
          end
        default:
          hc_r <= HC_ON;
      endcase
    end

  // battery short recovery
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      bs_r     <= BS_RUN;
      bs_cnt_r <= '0;
    end
    else
    begin
      bs_cnt_r <= bs_cnt_r + 32'h1;
      case (bs_r)
        BS_RUN:
          if (sn.bat_short)
          begin
            bs_r     <= BS_OPEN;
            bs_cnt_r <= '0;
          end
        BS_OPEN:
          if (bs_cnt_r >= 32'(P_BSHORT_CYC - 1))
            bs_r <= BS_LOW;
        BS_LOW:
          if (!sn.bat_short)
            bs_r <= BS_RUN;
        default:
          bs_r <= BS_RUN;
      endcase
    end

  // pins and analog controls
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      input_good_n <= 1'b1;
      stat_o       <= 1'b0;
      stat_oe      <= 1'b0;
      ctrl         <= '0;
    end
    else
    begin
      input_good_n              <= ~good;
      if (sn.chg_susp)
        stat_oe <= ms_tick ? ~stat_oe : stat_oe;
      else
        stat_oe <= sn.charging & ~sn.done;
      ctrl.conv_stop            <= sn.tsd | sn.system_overvoltage | sn.boost_ovp
                                 | (sn.input_overvoltage & ~sn.boost) | usb_hiz_r;
      ctrl.input_high_impedance <= hiz_r | usb_hiz_r;
      ctrl.charge_en            <= chg_en_r & ~sn.battery_overvoltage & ~safe_exp_r
                                 & ~usb_hiz_r & ~sn.tsd;
      ctrl.reduce_current       <= sn.treg;
      ctrl.term_off             <= sn.treg;
      ctrl.timer_half           <= sn.treg;
      ctrl.blocking_switch      <= (hc_r != HC_OFF);
      ctrl.battery_switch       <= (bs_r == BS_LOW) | ((bs_r == BS_RUN) & ~sn.bat_short
                                 & ~(sn.bat_low & ~sn.charging));
      ctrl.charge_100ma         <= (bs_r == BS_LOW);
      ctrl.boost_exit           <= sn.boost_ovp;
      ctrl.thermal_sel          <= thm_sel_r;
    end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  logic [31:0] int_len_r;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      int_len_r <= '0;
    else
      int_len_r <= int_oe ? int_len_r + 32'h1 : '0;

  AST_PG: assert property (!input_good_n |-> $past(sn.uvlo_ok && sn.above_bat && !sn.input_overvoltage && sn.src_ok))
    else $error("input good driven without good input");
  AST_STAT: assert property (sn.charging && !sn.done && !sn.chg_susp |=> stat_oe)
    else $error("charge state pin not low while charging");
  AST_INT_LEN: assert property ($fell(int_oe) |-> int_len_r >= 32'(P_INT_CYC))
    else $error("interrupt pulse too short");
  AST_FLT_HOLD: assert property (bat_flt_r && !rd_fault |=> bat_flt_r)
    else $error("latched fault lost without read");
  AST_SUPPRESS: assert property (pend_r && flt_ev && $stable(sn.thermistor) && $stable(good)
    && !$rose(sn.src_id) && !$rose(sn.done) && int_cnt_r == 32'h0 |=> !int_oe)
    else $error("interrupt on fault while one is unread");
  AST_NTC: assert property (rd_fault |=> s_axi_rdata[2:0] == $past(sn.thermistor))
    else $error("thermistor field not live");
  AST_TSD: assert property ($rose(sn.tsd) |=> chg_flt_r == CF_TSD ##1 ctrl.conv_stop)
    else $error("thermal shutdown not handled");
  AST_BOVP: assert property (sn.battery_overvoltage |=> !ctrl.charge_en)
    else $error("charging while battery overvoltage");
  AST_MODE: assert property (rd_fault |=> s_axi_rdata[7] == $past(default_r))
    else $error("mode bit wrong");
  AST_HOST: assert property (wr_go |=> !default_r)
    else $error("write did not enter host mode");
endmodule
`default_nettype wire

// [test/cs_host_model.sv]
// host side model issuing single AXI4-Lite register transfers
`timescale 1ns/100ps
`default_nettype none
module cs_host_model (
  // clock
  input  wire logic        clk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;

  // one word per transfer, never a burst
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready && awvalid)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wready && wvalid)
      begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  // single read, fault register read once per call
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready && arvalid)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test/cs_supervisor_bench.sv]
// self-checking bench for the charger supervisor
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module cs_supervisor_bench;
  import cs_pkg::*;
  localparam int INT_LEN = 8;
  localparam logic [7:0] ADR [5] = '{A_CHG_CTRL, A_TMR_CTRL, A_THM_CTRL, A_IN_SRC, A_FAULT};
  localparam logic [31:0] RST [5] = '{32'(RST_CHG_EN) << B_CHG_EN, 32'(RST_WD_SEL) << 4,
                                      32'(RST_THM_SEL), 32'(RST_HIZ) << B_HIZ, 32'h80};
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  cs_sense_t   sense = '0;
  cs_ctrl_t    ctrl;
  logic        input_good_n, stat_o, stat_oe, int_o, int_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        b;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int          fails = 0;
  int          samples_checked = 0;

  always #20 clk = ~clk;

  cs_supervisor #(.P_MS_CYC(4), .P_INT_CYC(INT_LEN), .P_HC_OFF_CYC(20), .P_HC_ON_CYC(5),
                  .P_BSHORT_CYC(6), .P_USB_MS(5), .P_SAFE_MS(1000)) DUT (
    .clk, .rst_n, .sense, .input_good_n, .stat_o, .stat_oe, .int_o, .int_oe, .ctrl,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  cs_host_model host (.clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    `CHK("rdata", e, d)
  endtask

  // waits for an interrupt and measures how long it is held
  task automatic pulse(input int e);
    int n;
    int w;
    n = 0;
    w = 0;
    while (!int_oe && w < 40)
    begin
      @(posedge clk);
      w++;
    end
    while (int_oe && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    `CHK("int_len", e, n)
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("od_data", 2'h0, {stat_o, int_o})
    `CHK("input_good_n", 1'b1, input_good_n)
    sense.uvlo_ok <= 1'b1;
    sense.above_bat <= 1'b1;
    sense.src_ok <= 1'b1;
    pulse(INT_LEN);
    `CHK("input_good_n", 1'b0, input_good_n)
    foreach (ADR[i]) rd_chk(ADR[i], RST[i]);
    host.rd(8'h1c, d, r);
    `CHK("rresp", RESP_ERR, r)
    sense.treg <= 1'b1;
    repeat (5) @(posedge clk);
    rd_chk(A_STATUS, 32'h02);
    `CHK("treg_ctrl", 5'h1f, {ctrl.reduce_current, ctrl.term_off, ctrl.timer_half, ctrl.thermal_sel})
    sense.treg <= 1'b0;
    sense.system_overvoltage <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("conv_stop", 1'b1, ctrl.conv_stop)
    sense.system_overvoltage <= 1'b0;
    sense.input_overvoltage <= 1'b1;
    pulse(INT_LEN);
    `CHK("input_good_n", 1'b1, input_good_n)
    `CHK("conv_stop", 1'b1, ctrl.conv_stop)
    sense.input_overvoltage <= 1'b0;
    pulse(INT_LEN);
    rd_chk(A_FAULT, 32'h90);
    rd_chk(A_FAULT, 32'h80);
    sense.tsd <= 1'b1;
    pulse(INT_LEN);
    `CHK("conv_stop", 1'b1, ctrl.conv_stop)
    sense.battery_overvoltage <= 1'b1;
    pulse(0);
    sense.thermistor <= 3'h2;
    pulse(INT_LEN);
    sense.tsd <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("charge_en", 1'b0, ctrl.charge_en)
    rd_chk(A_FAULT, 32'haa);
    rd_chk(A_FAULT, 32'h8a);
    sense.battery_overvoltage <= 1'b0;
    sense.thermistor <= 3'h0;
    pulse(INT_LEN);
    sense.charging <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK("stat_oe", 1'b1, stat_oe)
    sense.charging <= 1'b0;
    sense.done <= 1'b1;
    pulse(INT_LEN);
    `CHK("stat_oe", 1'b0, stat_oe)
    sense.done <= 1'b0;
    sense.chg_susp <= 1'b1;
    repeat (6) @(posedge clk);
    b = stat_oe;
    repeat (4) @(posedge clk);
    `CHK("stat_blink", ~b, stat_oe)
    sense.chg_susp <= 1'b0;
    sense.src_id <= 1'b1;
    sense.src_100ma <= 1'b1;
    sense.charging <= 1'b1;
    pulse(INT_LEN);
    `CHK("input_hiz", 1'b0, ctrl.input_high_impedance)
    repeat (20) @(posedge clk);
    `CHK("usb_stop", 2'h3, {ctrl.conv_stop, ctrl.input_high_impedance})
    rd_chk(A_IN_SRC, 32'h80);
    sense.uvlo_ok <= 1'b0;
    sense.src_id <= 1'b0;
    sense.src_100ma <= 1'b0;
    sense.charging <= 1'b0;
    pulse(INT_LEN);
    `CHK("input_hiz", 1'b0, ctrl.input_high_impedance)
    sense.uvlo_ok <= 1'b1;
    pulse(INT_LEN);
    sense.boost <= 1'b1;
    sense.boost_ocp <= 1'b1;
    pulse(INT_LEN);
    `CHK("blocking_switch", 1'b0, ctrl.blocking_switch)
    repeat (14) @(posedge clk);
    `CHK("blocking_switch", 1'b1, ctrl.blocking_switch)
    repeat (5) @(posedge clk);
    `CHK("blocking_switch", 1'b0, ctrl.blocking_switch)
    sense.boost_ocp <= 1'b0;
    repeat (30) @(posedge clk);
    `CHK("blocking_switch", 1'b1, ctrl.blocking_switch)
    rd_chk(A_FAULT, 32'hc8);
    sense.boost_ovp <= 1'b1;
    pulse(INT_LEN);
    `CHK("boost_stop", 2'h3, {ctrl.conv_stop, ctrl.boost_exit})
    sense.boost_ovp <= 1'b0;
    sense.boost <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk(A_FAULT, 32'hc0);
    rd_chk(A_FAULT, 32'h80);
    sense.bat_short <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("battery_switch", 1'b0, ctrl.battery_switch)
    repeat (4) @(posedge clk);
    `CHK("short_charge", 2'h3, {ctrl.battery_switch, ctrl.charge_100ma})
    sense.bat_short <= 1'b0;
    sense.bat_low <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK("deep_discharge", 2'h0, {ctrl.battery_switch, ctrl.charge_100ma})
    sense.bat_low <= 1'b0;
    host.wr(A_TMR_CTRL, 32'h0, 4'hf, r);
    `CHK("bresp", RESP_OK, r)
    rd_chk(A_TMR_CTRL, 32'h0);
    host.wr(A_THM_CTRL, 32'h1, 4'h0, r);
    rd_chk(A_THM_CTRL, 32'(RST_THM_SEL));
    host.wr(A_THM_CTRL, 32'h1, 4'hf, r);
    rd_chk(A_THM_CTRL, 32'h1);
    `CHK("thermal_sel", 2'h1, ctrl.thermal_sel)
    rd_chk(A_FAULT, 32'h0);
    sense.charging <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK("charge_en", 1'b1, ctrl.charge_en)
    repeat (4100) @(posedge clk);
    `CHK("charge_en", 1'b0, ctrl.charge_en)
    rd_chk(A_FAULT, 32'h30);
    sense.charging <= 1'b0;
    host.wr(A_CHG_CTRL, 32'h0, 4'hf, r);
    host.wr(A_CHG_CTRL, 32'h10, 4'hf, r);
    repeat (2) @(posedge clk);
    `CHK("charge_en", 1'b1, ctrl.charge_en)
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
